// ===== design/rwf_pkg.sv
/*
 * rwf_pkg: shared constants and types of the receive frame filter and wake block.
 * Assumes a 16-bit register view reached through word-aligned APB indices.
 */
package rwf_pkg;

   // ****************************************
   // register indices, byte address is index * 4
   // ****************************************
   localparam logic [9:0] RWF_IDX_CFG = 10'h134;
   localparam logic [9:0] RWF_IDX_STATUS = 10'h135;
   localparam logic [9:0] RWF_IDX_MATCH_LO = 10'h136;
   localparam logic [9:0] RWF_IDX_MATCH_MID = 10'h137;
   localparam logic [9:0] RWF_IDX_MATCH_HI = 10'h138;
   localparam logic [9:0] RWF_IDX_PASS_LO = 10'h139;
   localparam logic [9:0] RWF_IDX_PASS_MID = 10'h13A;
   localparam logic [9:0] RWF_IDX_PASS_HI = 10'h13B;
   localparam logic [9:0] RWF_IDX_IRQ_STAT = 10'h150;
   localparam logic [9:0] RWF_IDX_IRQ_MASK = 10'h151;

   // ****************************************
   // field positions
   // ****************************************
   localparam int RWF_CFG_CLEAN = 11;
   localparam int RWF_CFG_WIDTH_LSB = 9;
   localparam int RWF_CFG_STYLE = 8;
   localparam int RWF_CFG_FEAT = 7;
   localparam int RWF_CFG_UCAST = 4;
   localparam int RWF_CFG_BCAST = 2;
   localparam int RWF_CFG_PATT = 1;
   localparam int RWF_CFG_MAGIC = 0;
   localparam int RWF_EV_MAGIC = 0;
   localparam int RWF_EV_PATT = 1;
   localparam int RWF_EV_BCAST = 2;
   localparam int RWF_EV_UCAST = 4;
   localparam int RWF_EV_CRC = 6;
   localparam int RWF_EV_SFD = 7;

   // ****************************************
   // reset values and counts
   // ****************************************
   localparam logic [15:0] RWF_CFG_RST = 16'h1000;
   localparam logic [7:0] RWF_STATUS_RST = 8'h00;
   localparam logic [7:0] RWF_MASK_RST = 8'h17;
   localparam logic [6:0] RWF_PULSE_BASE = 7'h08;
   localparam logic [2:0] RWF_SYNC_BYTES = 3'h6;
   localparam logic [2:0] RWF_LAST_COL = 3'h5;
   localparam logic [3:0] RWF_LAST_REP = 4'hF;
   localparam logic [7:0] RWF_BYTE_ONES = 8'hFF;

   typedef enum logic [1:0] {MG_SYNC, MG_ADDR, MG_PASS, MG_DONE} rwf_magic_t;

endpackage : rwf_pkg

// ===== design/rwf_filter.sv
/*
 * rwf_filter: receive frame classifier, event status, interrupt and wake output.
 * Assumes a byte stream on sys_clk_i from the receive path, plus pattern and
 * delimiter error pulses from neighbouring logic, and an APB master.
 */
// Implementation choice: register access over APB.
// How it works
// - config bit 8 picks wake output style, 0 pulse, 1 held level.
// - pulse style width is 8, 16, 32 or 64 cycles by bits 10-9.
// - held level drops when software writes 1 to bit 11; bit reads level.
// - unicast wake enable bit 4 raises interrupt per unicast frame.
// - broadcast wake enable bit 2 raises interrupt per broadcast frame.
// - pattern wake enable bit 1 raises interrupt per pattern frame.
// - magic wake enable bit 0 raises interrupt per magic frame.
// - status bit 0 flags magic frame, cleared by status read.
// - status bit 1 flags pattern frame, cleared by status read.
// - status bit 2 flags broadcast frame, cleared by status read.
// - status bit 4 flags unicast frame, cleared by status read.
// - status bit 6 flags bad CRC, bit 7 delimiter error; read clears.
// - destination address compared with 48-bit match from three words.
// - magic frame checks 48-bit password held in three words, unless it is zero.
`timescale 1ns/100ps
module rwf_filter
   import rwf_pkg::*;
(
   input wire logic sys_clk_i,          // 200 MHz clock
   input wire logic nrst_i,             // sync reset, active low
   input wire logic psel_i,             // apb select
   input wire logic penable_i,          // apb enable
   input wire logic pwrite_i,           // apb direction
   input wire logic [11:0] paddr_i,     // apb byte address
   input wire logic [31:0] pwdata_i,    // apb write data
   output logic [31:0] prdata_o,        // apb read data
   output logic pready_o,               // apb ready
   output logic pslverr_o,              // apb error
   input wire logic rx_valid_i,         // byte valid
   input wire logic rx_sof_i,           // first byte of frame
   input wire logic rx_eof_i,           // last byte of frame
   input wire logic [7:0] rx_data_i,    // received byte
   input wire logic rx_crc_err_i,       // crc wrong, with eof
   input wire logic rx_pattern_hit_i,   // pattern matched in frame
   input wire logic rx_delimiter_error_flag_i,       // delimiter error pulse
   output logic irq_o,                  // level interrupt
   output logic wake_o                  // wake indication to gpio
);

   // ****************************************
   // state
   // ****************************************
   logic [15:0] cfg_reg, cfg_next;
   logic [7:0] status_reg, status_next;
   logic [7:0] irq_stat_reg, irq_stat_next;
   logic [7:0] irq_mask_reg, irq_mask_next;
   logic [15:0] match_reg [3];
   logic [15:0] match_next [3];
   logic [15:0] pass_reg [3];
   logic [15:0] pass_next [3];
   logic [31:0] prdata_reg, prdata_next;
   logic err_reg, err_next;
   logic [47:0] da_reg, da_next;
   logic [2:0] da_cnt_reg, da_cnt_next;
   logic patt_reg, patt_next;
   rwf_magic_t mg_state_reg, mg_state_next;
   logic [2:0] mg_ff_reg, mg_ff_next;
   logic [2:0] mg_col_reg, mg_col_next;
   logic [3:0] mg_rep_reg, mg_rep_next;
   logic wake_level_reg, wake_level_next;
   logic [6:0] wake_cnt_reg, wake_cnt_next;
   logic wake_out_reg, wake_out_next;

   logic setup, access, wr_acc;
   logic [9:0] idx;
   logic [47:0] match_val, pass_val;
   logic frame_end, good_end, feat_on;
   logic ucast_hit, bcast_hit, patt_hit, magic_hit, crc_hit, sfd_hit;
   logic [7:0] events, irq_events;
   logic wake_trig, clean_wr, style;
   logic [1:0] width_sel;

   function automatic logic [7:0] pick_byte(input logic [47:0] v, input logic [2:0] col);
      // byte 0 on the wire is the top byte of the value
      logic [7:0] b;
      b = 8'h00;
      unique case (col)
         3'h0: b = v[47:40];
         3'h1: b = v[39:32];
         3'h2: b = v[31:24];
         3'h3: b = v[23:16];
         3'h4: b = v[15:8];
         default: b = v[7:0];
      endcase
      return b;
   endfunction : pick_byte

   assign setup = psel_i & ~penable_i;
   assign access = psel_i & penable_i;
   assign wr_acc = access & pwrite_i;
   assign idx = paddr_i[11:2];
   assign match_val = {match_reg[2], match_reg[1], match_reg[0]};
   assign pass_val = {pass_reg[2], pass_reg[1], pass_reg[0]};
   assign style = cfg_reg[RWF_CFG_STYLE];
   assign width_sel = cfg_reg[RWF_CFG_WIDTH_LSB +: 2];
   assign clean_wr = wr_acc && idx == RWF_IDX_CFG && pwdata_i[RWF_CFG_CLEAN];

   // ****************************************
   // frame classification
   // ****************************************
   // without the feature enable the filter stays silent, except delimiter errors
   assign feat_on = cfg_reg[RWF_CFG_FEAT];
   assign frame_end = rx_valid_i & rx_eof_i & feat_on;
   assign good_end = frame_end & ~rx_crc_err_i;
   assign ucast_hit = good_end && da_next == match_val;
   assign bcast_hit = good_end && da_next == {6{RWF_BYTE_ONES}};
   assign patt_hit = good_end & patt_next;
   assign magic_hit = good_end && mg_state_next == MG_DONE;
   assign crc_hit = frame_end & rx_crc_err_i;
   assign sfd_hit = rx_delimiter_error_flag_i;

   always_comb begin
      events = 8'h00;
      events[RWF_EV_MAGIC] = magic_hit;
      events[RWF_EV_PATT] = patt_hit;
      events[RWF_EV_BCAST] = bcast_hit;
      events[RWF_EV_UCAST] = ucast_hit;
      events[RWF_EV_CRC] = crc_hit;
      events[RWF_EV_SFD] = sfd_hit;
      irq_events = events;
      irq_events[RWF_EV_UCAST] = ucast_hit & cfg_reg[RWF_CFG_UCAST];
      irq_events[RWF_EV_BCAST] = bcast_hit & cfg_reg[RWF_CFG_BCAST];
      irq_events[RWF_EV_PATT] = patt_hit & cfg_reg[RWF_CFG_PATT];
      irq_events[RWF_EV_MAGIC] = magic_hit & cfg_reg[RWF_CFG_MAGIC];
   end

   assign wake_trig = |(irq_events[RWF_EV_UCAST:RWF_EV_MAGIC]);

   // destination capture and pattern memory per frame
   always_comb begin
      da_next = da_reg;
      da_cnt_next = da_cnt_reg;
      patt_next = patt_reg | rx_pattern_hit_i;
      if (rx_valid_i && rx_sof_i) begin
         da_next = {da_reg[39:0], rx_data_i};
         da_cnt_next = 3'h1;
         patt_next = rx_pattern_hit_i;
      end else if (rx_valid_i && da_cnt_reg != RWF_SYNC_BYTES) begin
         da_next = {da_reg[39:0], rx_data_i};
         da_cnt_next = da_cnt_reg + 3'h1;
      end
   end

   // ****************************************
   // magic frame detector
   // ****************************************
   // sync run of ones, sixteen copies of the match value, then the password
   always_comb begin
      rwf_magic_t st;
      logic [2:0] ff;
      logic is_ff;
      st = rx_sof_i ? MG_SYNC : mg_state_reg;
      ff = rx_sof_i ? 3'h0 : mg_ff_reg;
      is_ff = rx_data_i == RWF_BYTE_ONES;
      mg_state_next = mg_state_reg;
      mg_ff_next = mg_ff_reg;
      mg_col_next = mg_col_reg;
      mg_rep_next = mg_rep_reg;
      if (rx_valid_i) begin
         mg_state_next = st;
         mg_ff_next = ff;
         unique case (st)
            MG_SYNC: begin
               if (ff == RWF_SYNC_BYTES && rx_data_i == pick_byte(match_val, 3'h0)) begin
                  mg_state_next = MG_ADDR;
                  mg_col_next = 3'h1;
                  mg_rep_next = 4'h0;
               end else if (is_ff) begin
                  mg_ff_next = (ff == RWF_SYNC_BYTES) ? ff : ff + 3'h1;
               end else begin
                  mg_ff_next = 3'h0;
               end
            end
            MG_ADDR: begin
               if (rx_data_i != pick_byte(match_val, mg_col_reg)) begin
                  mg_state_next = MG_SYNC;
                  mg_ff_next = is_ff ? 3'h1 : 3'h0;
               end else if (mg_col_reg != RWF_LAST_COL) begin
                  mg_col_next = mg_col_reg + 3'h1;
               end else if (mg_rep_reg != RWF_LAST_REP) begin
                  mg_col_next = 3'h0;
                  mg_rep_next = mg_rep_reg + 4'h1;
               end else begin
                  // a zero password means none is demanded
                  mg_col_next = 3'h0;
                  mg_state_next = (pass_val == 48'h0) ? MG_DONE : MG_PASS;
               end
            end
            MG_PASS: begin
               if (rx_data_i != pick_byte(pass_val, mg_col_reg)) begin
                  mg_state_next = MG_SYNC;
                  mg_ff_next = is_ff ? 3'h1 : 3'h0;
               end else if (mg_col_reg != RWF_LAST_COL) begin
                  mg_col_next = mg_col_reg + 3'h1;
               end else begin
                  mg_state_next = MG_DONE;
               end
            end
            MG_DONE: mg_state_next = MG_DONE;
         endcase
      end
   end

   // ****************************************
   // wake output
   // ****************************************
   always_comb begin
      wake_level_next = wake_level_reg;
      wake_cnt_next = wake_cnt_reg;
      if (clean_wr) begin
         wake_level_next = 1'b0;
      end
      if (wake_trig && style) begin
         wake_level_next = 1'b1;
      end
      if (wake_trig && !style) begin
         wake_cnt_next = 7'(RWF_PULSE_BASE << width_sel) - 7'h01;
      end else if (wake_cnt_reg != 7'h00) begin
         wake_cnt_next = wake_cnt_reg - 7'h01;
      end
      if (style) begin
         wake_out_next = wake_level_next;
      end else begin
         wake_out_next = (wake_trig && !style) || wake_cnt_reg != 7'h00;
      end
   end

   // ****************************************
   // register file
   // ****************************************
   always_comb begin
      logic rd_status;
      rd_status = access && !pwrite_i && idx == RWF_IDX_STATUS;
      cfg_next = cfg_reg;
      irq_mask_next = irq_mask_reg;
      match_next = match_reg;
      pass_next = pass_reg;
      prdata_next = prdata_reg;
      err_next = err_reg;
      // clear only what the reader actually saw, new events survive
      status_next = status_reg & ~(rd_status ? prdata_reg[7:0] : 8'h00);
      irq_stat_next = irq_stat_reg;
      if (wr_acc) begin
         unique case (idx)
            RWF_IDX_CFG: cfg_next = pwdata_i[15:0];
            RWF_IDX_MATCH_LO: match_next[0] = pwdata_i[15:0];
            RWF_IDX_MATCH_MID: match_next[1] = pwdata_i[15:0];
            RWF_IDX_MATCH_HI: match_next[2] = pwdata_i[15:0];
            RWF_IDX_PASS_LO: pass_next[0] = pwdata_i[15:0];
            RWF_IDX_PASS_MID: pass_next[1] = pwdata_i[15:0];
            RWF_IDX_PASS_HI: pass_next[2] = pwdata_i[15:0];
            RWF_IDX_IRQ_STAT: irq_stat_next = irq_stat_reg & ~pwdata_i[7:0];
            RWF_IDX_IRQ_MASK: irq_mask_next = pwdata_i[7:0];
            default: ;
         endcase
      end
      cfg_next[RWF_CFG_CLEAN] = 1'b0;
      status_next = status_next | events;
      irq_stat_next = irq_stat_next | irq_events;
      if (setup) begin
         prdata_next = 32'h0000_0000;
         err_next = 1'b0;
         unique case (idx)
            RWF_IDX_CFG: begin
               prdata_next[15:0] = cfg_reg;
               prdata_next[RWF_CFG_CLEAN] = wake_level_reg;
            end
            RWF_IDX_STATUS: prdata_next[7:0] = status_reg;
            RWF_IDX_MATCH_LO: prdata_next[15:0] = match_reg[0];
            RWF_IDX_MATCH_MID: prdata_next[15:0] = match_reg[1];
            RWF_IDX_MATCH_HI: prdata_next[15:0] = match_reg[2];
            RWF_IDX_PASS_LO: prdata_next[15:0] = pass_reg[0];
            RWF_IDX_PASS_MID: prdata_next[15:0] = pass_reg[1];
            RWF_IDX_PASS_HI: prdata_next[15:0] = pass_reg[2];
            RWF_IDX_IRQ_STAT: prdata_next[7:0] = irq_stat_reg;
            RWF_IDX_IRQ_MASK: prdata_next[7:0] = irq_mask_reg;
            default: err_next = 1'b1;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         cfg_reg <= RWF_CFG_RST;
         status_reg <= RWF_STATUS_RST;
         irq_stat_reg <= RWF_STATUS_RST;
         irq_mask_reg <= RWF_MASK_RST;
         match_reg <= '{3{16'h0000}};
         pass_reg <= '{3{16'h0000}};
         prdata_reg <= 32'h0000_0000;
         err_reg <= 1'b0;
         da_reg <= 48'h0000_0000_0000;
         da_cnt_reg <= 3'h0;
         patt_reg <= 1'b0;
         mg_state_reg <= MG_SYNC;
         mg_ff_reg <= 3'h0;
         mg_col_reg <= 3'h0;
         mg_rep_reg <= 4'h0;
         wake_level_reg <= 1'b0;
         wake_cnt_reg <= 7'h00;
         wake_out_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         status_reg <= status_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         match_reg <= match_next;
         pass_reg <= pass_next;
         prdata_reg <= prdata_next;
         err_reg <= err_next;
         da_reg <= da_next;
         da_cnt_reg <= da_cnt_next;
         patt_reg <= patt_next;
         mg_state_reg <= mg_state_next;
         mg_ff_reg <= mg_ff_next;
         mg_col_reg <= mg_col_next;
         mg_rep_reg <= mg_rep_next;
         wake_level_reg <= wake_level_next;
         wake_cnt_reg <= wake_cnt_next;
         wake_out_reg <= wake_out_next;
      end
   end

   assign prdata_o = prdata_reg;
   assign pready_o = access;
   assign pslverr_o = access & err_reg;
   assign irq_o = |(irq_stat_reg & irq_mask_reg);
   assign wake_o = wake_out_reg;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_pulse8_start;
      wake_trig && !style && width_sel == 2'h0;
   endsequence
   sequence s_quiet8;
      (!wake_trig && !style)[*8];
   endsequence

   property p_pulse_end;
      s_pulse8_start ##1 s_quiet8 |=> !wake_o;
   endproperty
   a_pulse_end: assert property (p_pulse_end) else $error("pulse not 8 cycles");

   property p_pulse_high;
      s_pulse8_start |=> wake_o [*8];
   endproperty
   a_pulse_high: assert property (p_pulse_high) else $error("pulse short");

   property p_level_hold;
      style && wake_level_reg && !clean_wr ##1 style |-> wake_o;
   endproperty
   a_level_hold: assert property (p_level_hold) else $error("level dropped");

   property p_clean;
      clean_wr && !wake_trig && style |=> !wake_level_reg && !wake_o;
   endproperty
   a_clean: assert property (p_clean) else $error("level not cleared");

   property p_ucast;
      good_end && da_next == match_val && cfg_reg[RWF_CFG_UCAST]
         |=> status_reg[RWF_EV_UCAST] && irq_stat_reg[RWF_EV_UCAST];
   endproperty
   a_ucast: assert property (p_ucast) else $error("unicast lost");

   property p_bcast;
      bcast_hit && cfg_reg[RWF_CFG_BCAST]
         |=> status_reg[RWF_EV_BCAST] && irq_stat_reg[RWF_EV_BCAST];
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast lost");

   property p_patt;
      good_end && patt_next && cfg_reg[RWF_CFG_PATT]
         |=> status_reg[RWF_EV_PATT] && irq_stat_reg[RWF_EV_PATT];
   endproperty
   a_patt: assert property (p_patt) else $error("pattern lost");

   property p_magic;
      magic_hit && cfg_reg[RWF_CFG_MAGIC]
         |=> status_reg[RWF_EV_MAGIC] && irq_stat_reg[RWF_EV_MAGIC];
   endproperty
   a_magic: assert property (p_magic) else $error("magic lost");

   property p_errs;
      crc_hit || sfd_hit |=> status_reg[RWF_EV_CRC] || status_reg[RWF_EV_SFD];
   endproperty
   a_errs: assert property (p_errs) else $error("error flag lost");

   property p_read_clear;
      access && !pwrite_i && idx == RWF_IDX_STATUS && events == 8'h00
         |=> (status_reg & $past(prdata_reg[7:0])) == 8'h00;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("status kept");

   property p_wake_cause;
      !style && $rose(wake_o) |-> $past(wake_trig);
   endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("wake w/o event");

   // the unicast flag may only come up from a good frame with an exact address
   property p_ucast_exact;
      $rose(status_reg[RWF_EV_UCAST])
         |-> $past(good_end) && $past(da_next) == $past(match_val);
   endproperty
   a_ucast_exact: assert property (p_ucast_exact) else $error("bad unicast");

   property p_pass_fail;
      rx_valid_i && !rx_sof_i && mg_state_reg == MG_PASS
         && rx_data_i != pick_byte(pass_val, mg_col_reg) |=> mg_state_reg == MG_SYNC;
   endproperty
   a_pass_fail: assert property (p_pass_fail) else $error("password ignored");

endmodule : rwf_filter

// ===== verif/rwf_link_partner.sv
/*
 * rwf_link_partner: far-end frame source feeding the receive byte stream.
 * Assumes one bench process calls its tasks right after a rising edge.
 */
`timescale 1ns/100ps
module rwf_link_partner (
   input wire logic clk_i,      // bench clock
   output logic valid_o,        // byte strobe
   output logic sof_o,          // first byte
   output logic eof_o,          // last byte
   output logic [7:0] data_o,   // byte
   output logic crc_err_o,      // bad crc, with last byte
   output logic hit_o,          // pattern pulse
   output logic delimiter_error_flag_o       // delimiter error pulse
);
   initial begin
      {valid_o, sof_o, eof_o, crc_err_o, hit_o, delimiter_error_flag_o} = '0;
      data_o = 8'h5A;
   end

   // idle lane shows the inverse byte so a stale byte never passes as data
   task automatic idle();
      valid_o <= 1'b0;
      sof_o <= 1'b0;
      eof_o <= 1'b0;
      crc_err_o <= 1'b0;
      hit_o <= 1'b0;
      data_o <= ~data_o;
      @(posedge clk_i);
   endtask : idle

   task automatic send(input logic [7:0] b[$], input logic bad, input logic patt,
         input logic slow);
      for (int i = 0; i < b.size(); i++) begin
         valid_o <= 1'b1;
         sof_o <= (i == 0);
         eof_o <= (i == b.size() - 1);
         data_o <= b[i];
         crc_err_o <= bad && (i == b.size() - 1);
         hit_o <= patt && (i == 2);
         @(posedge clk_i);
         if (slow) idle();
      end
      idle();
   endtask : send

   task automatic sfd();
      delimiter_error_flag_o <= 1'b1;
      @(posedge clk_i);
      delimiter_error_flag_o <= 1'b0;
   endtask : sfd
endmodule : rwf_link_partner

// ===== verif/rwf_filter_bench.sv
/*
 * rwf_filter_bench: self-checking bench for rwf_filter over APB and frames.
 * Assumes the link partner model drives every receive input.
 */
`timescale 1ns/100ps
module rwf_filter_bench
   import rwf_pkg::*;
;
   logic sys_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, irq_o, wake_o;
   logic rx_valid, rx_sof, rx_eof, rx_crc, rx_hit, rx_sfd;
   logic [7:0] rx_data;
   logic [32:0] apq[$];
   int wq[$];
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   int wcnt = 0;
   logic lvl = 1'b0;
   logic [31:0] seed = 32'h0000_0EAB;
   logic [47:0] mv;
   logic [7:0] st[5] = '{8'h10, 8'h02, 8'h11, 8'h40, 8'h00};

   always #2.5 sys_clk_i = ~sys_clk_i;

   rwf_filter dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .rx_valid_i(rx_valid), .rx_sof_i(rx_sof),
      .rx_eof_i(rx_eof), .rx_data_i(rx_data), .rx_crc_err_i(rx_crc),
      .rx_pattern_hit_i(rx_hit), .rx_delimiter_error_flag_i(rx_sfd), .irq_o(irq_o), .wake_o(wake_o));
   rwf_link_partner lk (.clk_i(sys_clk_i), .valid_o(rx_valid), .sof_o(rx_sof),
      .eof_o(rx_eof), .data_o(rx_data), .crc_err_o(rx_crc), .hit_o(rx_hit),
      .delimiter_error_flag_o(rx_sfd));

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out

   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
         input logic [32:0] e);
      apq.push_back(e);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= {a, 2'b00};
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      @(posedge sys_clk_i);
      while (pready_o !== 1'b1) @(posedge sys_clk_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask : apb

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0_0000_0000);
   endtask : wr

   task automatic rd(input logic [9:0] a, input logic [15:0] e);
      apb(1'b0, a, 32'h0000_0000, {17'h0_0000, e});
   endtask : rd

   task automatic frame(input logic [47:0] da, input logic mg, input logic bad,
         input logic pt);
      logic [7:0] q[$];
      for (int i = 5; i >= 0; i--) q.push_back(da[i*8 +: 8]);
      if (mg) begin
         repeat (6) q.push_back(8'hFF);
         repeat (16) for (int i = 5; i >= 0; i--) q.push_back(mv[i*8 +: 8]);
      end
      repeat (4) q.push_back(seed[15:8]);
      lk.send(q, bad, pt, seed[0]);
      seed = xs(seed);
      repeat (2) @(posedge sys_clk_i);
   endtask : frame

   // ****************************************
   // monitors
   // ****************************************
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         close_out();
      end
      if (psel_i && penable_i && pready_o === 1'b1) begin
         check({pslverr_o, pwrite_i ? 32'h0000_0000 : prdata_o}, apq.pop_front());
      end
      if (wake_o === 1'b1) begin
         wcnt++;
      end else if (wcnt > 0) begin
         if (!lvl) check(33'(wcnt), 33'(wq.pop_front()));
         wcnt = 0;
      end
   end

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      repeat (12) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      @(posedge sys_clk_i);
      rd(RWF_IDX_CFG, 16'h1000);
      rd(RWF_IDX_STATUS, 16'h0000);
      rd(RWF_IDX_IRQ_MASK, 16'h0017);
      check({irq_o, wake_o}, 33'h0_0000_0000);
      seed = xs(seed);
      mv[31:0] = seed;
      seed = xs(seed);
      mv[47:32] = {seed[15:9], 1'b0, seed[7:0]};
      for (int i = 0; i < 3; i++) begin
         rd(RWF_IDX_MATCH_LO + 10'(i), 16'h0000);
         wr(RWF_IDX_MATCH_LO + 10'(i), {16'h0000, mv[i*16 +: 16]});
         rd(RWF_IDX_MATCH_LO + 10'(i), mv[i*16 +: 16]);
      end
      apb(1'b0, 10'h1FF, 32'h0000_0000, 33'h1_0000_0000);
      apb(1'b1, 10'h1FF, 32'h0000_FFFF, 33'h1_0000_0000);
      wr(RWF_IDX_CFG, 32'h0000_1017);
      frame(48'hFFFF_FFFF_FFFF, 1'b0, 1'b0, 1'b0);
      rd(RWF_IDX_STATUS, 16'h0000);
      for (int s = 0; s < 4; s++) begin
         wr(RWF_IDX_CFG, 32'h0000_1097 | (s << 9));
         wq.push_back(8 << s);
         frame(48'hFFFF_FFFF_FFFF, 1'b0, 1'b0, 1'b0);
         rd(RWF_IDX_STATUS, 16'h0004);
         rd(RWF_IDX_STATUS, 16'h0000);
         rd(RWF_IDX_IRQ_STAT, 16'h0004);
         wr(RWF_IDX_IRQ_STAT, 32'h0000_0004);
         check(33'(irq_o), 33'h0);
         repeat (60) @(posedge sys_clk_i);
      end
      wr(RWF_IDX_CFG, 32'h0000_1097);
      for (int k = 0; k < 5; k++) begin
         if (|(st[k] & 8'h17)) wq.push_back(8);
         frame(k == 3 ? 48'hFFFF_FFFF_FFFF : (k == 1 || k == 4) ? mv ^ 48'h1 : mv,
            k == 2, k == 3, k == 1);
         check(33'(irq_o), 33'(|(st[k] & 8'h17)));
         rd(RWF_IDX_STATUS, {8'h00, st[k]});
         wr(RWF_IDX_IRQ_STAT, 32'h0000_00FF);
         repeat (12) @(posedge sys_clk_i);
      end
      wr(RWF_IDX_PASS_LO, 32'h0000_0506);
      wr(RWF_IDX_PASS_MID, 32'h0000_0304);
      wr(RWF_IDX_PASS_HI, 32'h0000_0102);
      rd(RWF_IDX_PASS_MID, 16'h0304);
      wq.push_back(8);
      // magic run without password bytes must not count as magic
      frame(mv, 1'b1, 1'b0, 1'b0);
      rd(RWF_IDX_STATUS, 16'h0010);
      wr(RWF_IDX_IRQ_MASK, 32'h0000_0000);
      wq.push_back(8);
      frame(mv, 1'b0, 1'b0, 1'b0);
      rd(RWF_IDX_IRQ_STAT, 16'h0010);
      check(33'(irq_o), 33'h0);
      wr(RWF_IDX_IRQ_MASK, 32'h0000_0017);
      check(33'(irq_o), 33'h1);
      wr(RWF_IDX_IRQ_STAT, 32'h0000_0010);
      check(33'(irq_o), 33'h0);
      rd(RWF_IDX_STATUS, 16'h0010);
      wr(RWF_IDX_CFG, 32'h0000_1080);
      frame(48'hFFFF_FFFF_FFFF, 1'b0, 1'b0, 1'b0);
      rd(RWF_IDX_IRQ_STAT, 16'h0000);
      rd(RWF_IDX_STATUS, 16'h0004);
      lvl = 1'b1;
      wr(RWF_IDX_CFG, 32'h0000_1184);
      frame(48'hFFFF_FFFF_FFFF, 1'b0, 1'b0, 1'b0);
      repeat (80) @(posedge sys_clk_i);
      check(33'(wake_o), 33'h1);
      rd(RWF_IDX_CFG, 16'h1984);
      wr(RWF_IDX_CFG, 32'h0000_1984);
      check(33'(wake_o), 33'h0);
      rd(RWF_IDX_CFG, 16'h1184);
      lvl = 1'b0;
      lk.sfd();
      repeat (2) @(posedge sys_clk_i);
      rd(RWF_IDX_STATUS, 16'h0084);
      close_out();
   end
endmodule : rwf_filter_bench
